/* hw/brc_defs.svh */
// register offsets, field positions and timing constants for the buck control registers
// assumes: included by bare name from hw/ design files
`ifndef BRC_DEFS_SVH
`define BRC_DEFS_SVH

`define BRC_ADDR_W          8
`define BRC_DATA_W          8
`define BRC_OFF_MODE        8'h38
`define BRC_OFF_CONF        8'h39
`define BRC_OFF_SLEEP       8'h37
`define BRC_OFF_RUN_C       8'h3c
`define BRC_OFF_STBY_C      8'h3d

`define BRC_MODE_OMODE_BIT  5
`define BRC_MODE_SW_HI      3
`define BRC_MODE_SW_LO      0
`define BRC_CONF_SPEED_BIT  6
`define BRC_CONF_PH_HI      5
`define BRC_CONF_PH_LO      4
`define BRC_CONF_FQ_HI      3
`define BRC_CONF_FQ_LO      2
`define BRC_CONF_ILIM_BIT   0
`define BRC_VOLT_HI         4
`define BRC_VOLT_LO         0
`define BRC_RANGE_BIT       5

// writable masks, reserved positions zero
`define BRC_MASK_MODE       8'h2f
`define BRC_MASK_CONF       8'h7d
`define BRC_MASK_SLEEP      8'h3f
`define BRC_MASK_VOLT       8'h1f
// otp-loaded bits of the mode register, off-mode bit starts clear
`define BRC_OTP_MASK_MODE   8'h0f
`define BRC_PHASE_RST       2'h0

// stepping: 25 mV every 2.0 us or 4.0 us at 125 MHz
`define BRC_CLK_MHZ         125
`define BRC_STEP_FAST_NS    2000
`define BRC_STEP_SLOW_NS    4000
`define BRC_STEP_FAST_CYC   ((`BRC_STEP_FAST_NS * `BRC_CLK_MHZ) / 1000)
`define BRC_STEP_SLOW_CYC   ((`BRC_STEP_SLOW_NS * `BRC_CLK_MHZ) / 1000)
`define BRC_STEP_CNT_W      10

`endif

/* hw/brc_pkg.sv */
// types shared by the buck control register files
// assumes: brc_defs.svh on the include path
`include "brc_defs.svh"
`default_nettype none
package brc_pkg;
  typedef logic [`BRC_ADDR_W-1:0] brc_addr_t;
  typedef logic [`BRC_DATA_W-1:0] brc_data_t;
  typedef logic [4:0]             brc_vcode_t;
  typedef enum logic [1:0] {BRC_OFF_FULL, BRC_OFF_SLEEP, BRC_ON} brc_pstate_t;
endpackage
`default_nettype wire

/* hw/brc_step_timer.sv */
// dvs stepping pacer: one-cycle pulse per 25 mV step
// assumes: single clock, synchronous active-low reset copy
`include "brc_defs.svh"
`default_nettype none
module brc_step_timer (
  input  wire logic sys_clk,
  input  wire logic rst_sync_b,
  input  wire logic slow,
  output logic      step_en
);
  import brc_pkg::*;

  typedef struct packed {
    logic [`BRC_STEP_CNT_W-1:0] cnt;
    logic                       pulse;
  } brc_tmr_t;

  brc_tmr_t st_r;
  brc_tmr_t st_nxt;
  logic [`BRC_STEP_CNT_W-1:0] limit;

  // ************************************
  // period select
  // ************************************
  always_comb begin
    limit = slow ? `BRC_STEP_CNT_W'(`BRC_STEP_SLOW_CYC - 1)
                 : `BRC_STEP_CNT_W'(`BRC_STEP_FAST_CYC - 1);
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    if (st_r.cnt >= limit) begin
      st_nxt.cnt   = '0;
      st_nxt.pulse = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + `BRC_STEP_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign step_en = st_r.pulse;
endmodule
`default_nettype wire

/* hw/brc_regs.sv */
// buck b / buck c control register bank with host read/write port
// assumes: host port synchronous to sys_clk; otp defaults stable after reset release
//
// Operation
// [RULE1] The off-mode bit picks full off (0) or sleep (1) after a turn-off event.
// [RULE2] Mode register bits 3:0 hold the buck b switching mode with an otp default.
// [RULE3] The speed bit paces 25 mV steps at 2.0 us when clear and 4.0 us when set.
// [RULE4] The current-limit bit selects 2.75 A typical when clear and 2.0 A when set.
// [RULE5] Config bits 5:4 select the phase clock and reset to zero.
// [RULE6] Config bits 3:2 select the switching frequency with an otp default.
// [RULE7] The sleep-voltage range bit selects low (0) or high (1) voltage settings.
// [RULE8] Buck c run register bits 4:0 set the normal-operation output code.
// [RULE9] Buck c standby register bits 4:0 set the standby output code.
// [RULE10] Every register accepts host reads and writes at any time. Here a write in the otp load cycle after reset release is dropped.
// [RULE11] Reserved and unimplemented bits read as zero.
// [RULE12] Variable-default fields load from otp contents at reset.
// [RULE13] Sleep register bits 4:0 hold the buck b sleep-mode output code.
// [RULE14] Writes to reserved bits are dropped so they keep reading zero.
`include "brc_defs.svh"
`default_nettype none
module brc_regs (
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire brc_pkg::brc_addr_t  host_addr,
  input  wire brc_pkg::brc_data_t  host_wdata,
  input  wire logic                host_wr,
  input  wire logic                host_rd,
  output brc_pkg::brc_data_t       host_rdata,
  output logic                     host_rvalid,
  input  wire brc_pkg::brc_data_t  otp_mode,
  input  wire brc_pkg::brc_data_t  otp_conf,
  input  wire brc_pkg::brc_data_t  otp_sleep,
  input  wire brc_pkg::brc_data_t  otp_run_c,
  input  wire brc_pkg::brc_data_t  otp_stby_c,
  input  wire logic                turn_off,
  input  wire logic                turn_on,
  input  wire logic                standby,
  input  wire brc_pkg::brc_vcode_t b_target,
  output logic [1:0]               b_power_state,
  output logic [3:0]               buck_b_switching_mode,
  output logic                     buck_b_current_limit,
  output logic [1:0]               buck_b_phase_clock,
  output logic [1:0]               buck_b_switch_frequency,
  output logic                     buck_b_voltage_range,
  output brc_pkg::brc_vcode_t      buck_b_sleep_voltage,
  output brc_pkg::brc_vcode_t      b_vcode,
  output logic                     b_step_en,
  output brc_pkg::brc_vcode_t      buck_c_vcode
);
  import brc_pkg::*;

  typedef struct packed {
    logic        loaded;
    brc_data_t   mode;
    brc_data_t   conf;
    brc_data_t   sleep;
    brc_data_t   run_c;
    brc_data_t   stby_c;
    brc_data_t   rdata;
    logic        rvalid;
    brc_pstate_t pst;
    brc_vcode_t  vcode;
    brc_vcode_t  cvcode;
  } brc_st_t;

  brc_st_t st_r;
  brc_st_t st_nxt;
  logic    rst_meta_r;
  logic    rst_sync_r;
  logic    rst_sync_b;
  logic    step_en;

  // ************************************
  // reset release
  // ************************************
  // two flops, only the second is read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_sync_b = rst_sync_r;

  brc_step_timer u_step (
    .sys_clk    (sys_clk),
    .rst_sync_b (rst_sync_b),
    // [RULE3] pacing select
    .slow       (st_r.conf[`BRC_CONF_SPEED_BIT]),
    .step_en    (step_en)
  );

  // ************************************
  // next state
  // ************************************
  always_comb begin
    brc_vcode_t goal;
    goal = '0;
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (!st_r.loaded) begin
      // [RULE12] otp defaults
      st_nxt.loaded = 1'b1;
      // [RULE1] off-mode bit starts clear
      st_nxt.mode   = otp_mode & `BRC_OTP_MASK_MODE;
      st_nxt.conf   = otp_conf & `BRC_MASK_CONF;
      // [RULE5] phase resets zero
      st_nxt.conf[`BRC_CONF_PH_HI:`BRC_CONF_PH_LO] = `BRC_PHASE_RST;
      st_nxt.sleep  = otp_sleep & `BRC_MASK_SLEEP;
      st_nxt.run_c  = otp_run_c & `BRC_MASK_VOLT;
      st_nxt.stby_c = otp_stby_c & `BRC_MASK_VOLT;
    end else if (host_wr) begin
      // [RULE10] writes at any time after the otp load cycle
      // [RULE14] reserved bits masked
      case (host_addr)
        `BRC_OFF_MODE:   st_nxt.mode   = host_wdata & `BRC_MASK_MODE;
        `BRC_OFF_CONF:   st_nxt.conf   = host_wdata & `BRC_MASK_CONF;
        `BRC_OFF_SLEEP:  st_nxt.sleep  = host_wdata & `BRC_MASK_SLEEP;
        `BRC_OFF_RUN_C:  st_nxt.run_c  = host_wdata & `BRC_MASK_VOLT;
        `BRC_OFF_STBY_C: st_nxt.stby_c = host_wdata & `BRC_MASK_VOLT;
        default: ;
      endcase
    end
    if (host_rd) begin
      // [RULE11] unmapped and reserved read zero
      st_nxt.rvalid = 1'b1;
      case (host_addr)
        `BRC_OFF_MODE:   st_nxt.rdata = st_r.mode;
        `BRC_OFF_CONF:   st_nxt.rdata = st_r.conf;
        `BRC_OFF_SLEEP:  st_nxt.rdata = st_r.sleep;
        `BRC_OFF_RUN_C:  st_nxt.rdata = st_r.run_c;
        `BRC_OFF_STBY_C: st_nxt.rdata = st_r.stby_c;
        default:         st_nxt.rdata = '0;
      endcase
    end
    // [RULE1] off versus sleep
    case (st_r.pst)
      BRC_ON: begin
        if (turn_off) begin
          st_nxt.pst = st_r.mode[`BRC_MODE_OMODE_BIT] ? BRC_OFF_SLEEP : BRC_OFF_FULL;
        end
      end
      BRC_OFF_SLEEP, BRC_OFF_FULL: begin
        if (turn_on) begin
          st_nxt.pst = BRC_ON;
        end
      end
      default: st_nxt.pst = BRC_OFF_FULL;
    endcase
    // [RULE13] sleep code as goal
    case (st_r.pst)
      BRC_ON:        goal = b_target;
      BRC_OFF_SLEEP: goal = st_r.sleep[`BRC_VOLT_HI:`BRC_VOLT_LO];
      default:       goal = '0;
    endcase
    // [RULE3] one code step per pulse
    if (step_en) begin
      if (st_r.vcode < goal) begin
        st_nxt.vcode = st_r.vcode + 5'h1;
      end else if (st_r.vcode > goal) begin
        st_nxt.vcode = st_r.vcode - 5'h1;
      end
    end
    // [RULE8] [RULE9] run or standby code
    st_nxt.cvcode = standby ? st_r.stby_c[`BRC_VOLT_HI:`BRC_VOLT_LO]
                            : st_r.run_c[`BRC_VOLT_HI:`BRC_VOLT_LO];
  end

  // state register, released by the synced copy
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r.loaded <= 1'b0;
      st_r.mode   <= '0;
      st_r.conf   <= '0;
      st_r.sleep  <= '0;
      st_r.run_c  <= '0;
      st_r.stby_c <= '0;
      st_r.rdata  <= '0;
      st_r.rvalid <= 1'b0;
      st_r.pst    <= BRC_OFF_FULL;
      st_r.vcode  <= '0;
      st_r.cvcode <= '0;
    end else begin
      st_r.loaded <= st_nxt.loaded;
      st_r.mode   <= st_nxt.mode;
      st_r.conf   <= st_nxt.conf;
      st_r.sleep  <= st_nxt.sleep;
      st_r.run_c  <= st_nxt.run_c;
      st_r.stby_c <= st_nxt.stby_c;
      st_r.rdata  <= st_nxt.rdata;
      st_r.rvalid <= st_nxt.rvalid;
      st_r.pst    <= st_nxt.pst;
      st_r.vcode  <= st_nxt.vcode;
      st_r.cvcode <= st_nxt.cvcode;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign host_rdata              = st_r.rdata;
  assign host_rvalid             = st_r.rvalid;
  assign b_power_state           = st_r.pst;
  // [RULE2] switching mode field
  assign buck_b_switching_mode   = st_r.mode[`BRC_MODE_SW_HI:`BRC_MODE_SW_LO];
  // [RULE4] limit select
  assign buck_b_current_limit    = st_r.conf[`BRC_CONF_ILIM_BIT];
  assign buck_b_phase_clock      = st_r.conf[`BRC_CONF_PH_HI:`BRC_CONF_PH_LO];
  // [RULE6] frequency select
  assign buck_b_switch_frequency = st_r.conf[`BRC_CONF_FQ_HI:`BRC_CONF_FQ_LO];
  // [RULE7] range select
  assign buck_b_voltage_range    = st_r.sleep[`BRC_RANGE_BIT];
  assign buck_b_sleep_voltage    = st_r.sleep[`BRC_VOLT_HI:`BRC_VOLT_LO];
  assign b_vcode                 = st_r.vcode;
  assign b_step_en               = step_en;
  assign buck_c_vcode            = st_r.cvcode;
endmodule
`default_nettype wire

/* verif/brc_chk_checker.sv */
// checker on the buck control register port
// assumes: bound to brc_regs, one clock domain
`default_nettype none
module brc_chk (
  input wire logic                sys_clk,
  input wire logic                rst_b,
  input wire brc_pkg::brc_addr_t  host_addr,
  input wire brc_pkg::brc_data_t  host_wdata,
  input wire logic                host_wr,
  input wire logic                host_rd,
  input wire brc_pkg::brc_data_t  host_rdata,
  input wire logic                host_rvalid,
  input wire logic                turn_off,
  input wire logic [1:0]          b_power_state,
  input wire logic [3:0]          buck_b_switching_mode,
  input wire logic                buck_b_current_limit,
  input wire logic [1:0]          buck_b_phase_clock,
  input wire logic [1:0]          buck_b_switch_frequency,
  input wire logic                buck_b_voltage_range,
  input wire brc_pkg::brc_vcode_t buck_b_sleep_voltage,
  input wire logic                b_step_en
);
  import brc_pkg::*;
  logic [2:0] up_r;
  logic       live;
  // counts edges past reset so the otp load is over
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  assign live = (up_r == 3'h7);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (live && host_rd |=> host_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (host_rvalid |-> $past(host_rd))
    else $error("answer without read");
  a_unmapped_zero: assert property (live && host_rd &&
    !(host_addr inside {8'h37, 8'h38, 8'h39, 8'h3c, 8'h3d}) |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_reserved: assert property (live && host_rd && host_addr == 8'h38
    |=> (host_rdata & 8'hd0) == 8'h00) else $error("mode reserved bits set");
  a_conf_reserved: assert property (live && host_rd && host_addr == 8'h39
    |=> (host_rdata & 8'h82) == 8'h00) else $error("config reserved bits set");
  a_mode_write: assert property (live && host_wr && host_addr == 8'h38
    |=> buck_b_switching_mode == $past(host_wdata[3:0])) else $error("mode not written");
  a_conf_write: assert property (live && host_wr && host_addr == 8'h39
    |=> {buck_b_phase_clock, buck_b_switch_frequency, buck_b_current_limit}
    == {$past(host_wdata[5:2]), $past(host_wdata[0])}) else $error("config not written");
  a_sleep_write: assert property (live && host_wr && host_addr == 8'h37
    |=> {buck_b_voltage_range, buck_b_sleep_voltage} == $past(host_wdata[5:0]))
    else $error("sleep register not written");
  a_off_target: assert property (live && turn_off && b_power_state == 2'h2
    |=> b_power_state inside {2'h0, 2'h1}) else $error("turn-off left buck on");
  a_step_single: assert property (b_step_en |=> !b_step_en [*8])
    else $error("step pulses too close");
endmodule
bind brc_regs brc_chk u_chk (.*);
`default_nettype wire

/* verif/brc_host_model.sv */
// host model: single-byte register reads and writes
// assumes: strobes sampled on rising sys_clk, answer one cycle later
`default_nettype none
module brc_host_model (
  input  wire logic               sys_clk,
  output var brc_pkg::brc_addr_t  host_addr,
  output var brc_pkg::brc_data_t  host_wdata,
  output var logic                host_wr,
  output var logic                host_rd,
  input  wire brc_pkg::brc_data_t host_rdata,
  input  wire logic               host_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  import brc_pkg::*;
  initial begin
    host_addr = 8'h00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  task automatic wr(input brc_addr_t a, input brc_data_t d);
    @(posedge sys_clk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  task automatic rd(input brc_addr_t a, output brc_data_t d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk);
    #1;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    host_rd = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (host_rvalid === 1'b1) begin
        d = host_rdata;
        ok = 1'b1;
      end else begin
        @(posedge sys_clk);
        #1;
      end
    end
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the buck control register bank
// assumes: package, design, host model and checker compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import brc_pkg::*;
  logic       sys_clk, rst_b, turn_off, turn_on, standby, host_wr, host_rd, host_rvalid;
  logic       b_step_en, buck_b_current_limit, buck_b_voltage_range;
  logic [1:0] b_power_state, buck_b_phase_clock, buck_b_switch_frequency;
  logic [3:0] buck_b_switching_mode;
  brc_addr_t  host_addr;
  brc_data_t  host_wdata, host_rdata;
  brc_vcode_t b_target, buck_b_sleep_voltage, b_vcode, buck_c_vcode;
  int         failures = 0;
  int         cmp_count = 0;
  brc_addr_t  adr [5] = '{8'h37, 8'h38, 8'h39, 8'h3c, 8'h3d};
  brc_data_t  msk [5] = '{8'h3f, 8'h2f, 8'h7d, 8'h1f, 8'h1f};
  brc_data_t  dfm [5] = '{8'h3f, 8'h0f, 8'h4d, 8'h1f, 8'h1f};
  brc_data_t  otp_img = 8'hff;
  brc_regs dut (.otp_mode(otp_img), .otp_conf(otp_img), .otp_sleep(otp_img),
    .otp_run_c(otp_img), .otp_stby_c(otp_img), .*);
  brc_host_model u_host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input brc_addr_t a, input brc_data_t e);
    brc_data_t d;
    logic      ok;
    u_host.rd(a, d, ok);
    if (!ok) begin
      failures++;
      close_out();
    end else begin
      chk("read data", 16'(e), 16'(d));
    end
  endtask
  task automatic pulse(input logic off, input logic [1:0] e);
    @(posedge sys_clk);
    #1;
    turn_off = off;
    turn_on = !off;
    @(posedge sys_clk);
    #1;
    turn_off = 1'b0;
    turn_on = 1'b0;
    chk("power state", 16'(e), 16'(b_power_state));
  endtask
  task automatic gap(input logic [15:0] e);
    logic [15:0] n;
    n = 16'h0;
    while (b_step_en !== 1'b1 && n < 16'd1200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    n = 16'h0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (b_step_en !== 1'b1 && n < 16'd1200);
    chk("step gap", e, n);
    if (n >= 16'd1200) close_out();
  endtask
  initial begin
    {rst_b, turn_off, turn_on, standby} = 4'h0;
    b_target = 5'h10;
    repeat (20) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) rchk(adr[i], otp_img & dfm[i]);
    for (int i = 0; i < 5; i++) begin
      u_host.wr(adr[i], 8'hff);
      rchk(adr[i], msk[i]);
      u_host.wr(adr[i], 8'h00);
      rchk(adr[i], 8'h00);
    end
    u_host.wr(8'h3a, 8'hff);
    rchk(8'h3a, 8'h00);
    u_host.wr(8'h38, 8'h25);
    u_host.wr(8'h39, 8'h59);
    u_host.wr(8'h37, 8'h2a);
    u_host.wr(8'h3c, 8'h13);
    u_host.wr(8'h3d, 8'h0c);
    chk("mode", 16'h5, 16'(buck_b_switching_mode));
    chk("conf", 16'h6, 16'({buck_b_phase_clock, buck_b_switch_frequency}));
    chk("limit", 16'h1, 16'(buck_b_current_limit));
    chk("sleep", 16'h2a, 16'({buck_b_voltage_range, buck_b_sleep_voltage}));
    repeat (2) @(posedge sys_clk);
    #1;
    chk("run code", 16'h13, 16'(buck_c_vcode));
    standby = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("standby code", 16'h0c, 16'(buck_c_vcode));
    pulse(1'b0, 2'h2);
    pulse(1'b1, 2'h1);
    pulse(1'b0, 2'h2);
    u_host.wr(8'h38, 8'h05);
    pulse(1'b1, 2'h0);
    gap(16'd500);
    u_host.wr(8'h39, 8'h19);
    gap(16'd250);
    b_target = 5'h02;
    pulse(1'b0, 2'h2);
    gap(16'd250);
    gap(16'd250);
    chk("run ramp", 16'h02, 16'(b_vcode));
    u_host.wr(8'h38, 8'h25);
    pulse(1'b1, 2'h1);
    repeat (2600) @(posedge sys_clk);
    #1;
    chk("sleep ramp", 16'h0a, 16'(b_vcode));
    otp_img = 8'h5a;
    rst_b = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("reset state", 16'h0, 16'(b_power_state));
    rst_b = 1'b1;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) rchk(adr[i], otp_img & dfm[i]);
    close_out();
  end
endmodule
`default_nettype wire
